// ===== design/gdc_decoder.sv
`timescale 1ns/100ps
// What this block does
// - Uniline lines are true when driven low.
// - ATN true: bytes are commands or addresses.
// - ATN false: bytes go to command parser when listen addressed.
// - REN true puts device remote, optional lockout.
// - Byte carrying EOI ends the message.
// - IFC idles talker and listener at once.
// - Device drives SRQ when it needs service.
// - Universal commands act without addressing.
// - Local lockout disables front panel operation.
// - Device clear returns device to defaults.
// - Serial poll enable enters serial poll mode.
// - Serial poll disable leaves serial poll mode.
// - Addressed commands need own listen address first.
// - Selective clear acts only when listen addressed.
// - Go to local when addressed restores local.
// - Group trigger when addressed starts triggered action.
// - Listen byte is address OR 20 hex.
// - Talk byte is address OR 40 hex.
// - Secondary group bytes change nothing here.
// - Unlisten drops listener, untalk drops talker.
// - Primary address valid from 0 to 30.
// - DIO1 is bit zero, DIO8 bit seven.
// - Listener paces with NRFD and NDAC.
module gdc_decoder
	import gdc_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// Bus lines in, active low
	input wire logic atn_n_i,
	input wire logic ifc_n_i,
	input wire logic ren_n_i,
	input wire logic eoi_n_i,
	input wire logic dav_n_i,
	input wire logic [7:0] dio_n_i,
	// Acceptor handshake lines out, open drain
	input wire logic nrfd_n_i,
	output logic nrfd_n_o,
	output logic nrfd_oe_n_o,
	input wire logic ndac_n_i,
	output logic ndac_n_o,
	output logic ndac_oe_n_o,
	// Service request line, open drain
	input wire logic srq_n_i,
	output logic srq_n_o,
	output logic srq_oe_n_o,
	// Instrument side configuration
	input wire logic [4:0] primary_addr_i,
	input wire logic ren_lockout_cfg_i,
	input wire logic srq_request_i,
	// Interface state
	output logic remote_o,
	output logic lockout_o,
	output logic listener_o,
	output logic talker_o,
	output logic serial_poll_o,
	// Events to instrument
	output logic dev_clear_o,
	output logic trigger_o,
	// Device-dependent data stream
	output logic [7:0] data_o,
	output logic data_valid_o,
	output logic data_last_o
);

	// ----------------------------------------
	// Input synchronisers and agreement filter
	// ----------------------------------------
	logic [GDC_LINE_W-1:0] pins_raw;
	logic [GDC_LINE_W-1:0] sync1_reg;
	logic [GDC_LINE_W-1:0] sync2_reg;
	logic [GDC_LINE_W-1:0] sync3_reg;
	logic [GDC_LINE_W-1:0] flt_reg;
	gdc_lines_s lines;

	// Invert to true levels: low on the wire is true
	assign pins_raw = ~{atn_n_i, ifc_n_i, ren_n_i, eoi_n_i, dav_n_i, dio_n_i};

	// Three stage shift of the raw lines
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			sync1_reg <= GDC_LINES_RST;
			sync2_reg <= GDC_LINES_RST;
			sync3_reg <= GDC_LINES_RST;
		end
		else
		begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// Each bit changes once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < GDC_LINE_W; gi++)
		begin : g_flt
			always_ff @(posedge mclk_i)
			begin
				if (reset_i)
					flt_reg[gi] <= 1'b0;
				else if (sync2_reg[gi] == sync3_reg[gi])
					flt_reg[gi] <= sync3_reg[gi];
			end
		end
	endgenerate

	assign lines = gdc_lines_s'(flt_reg);

	// ----------------------------------------
	// Acceptor handshake
	// ----------------------------------------
	gdc_hs_e hs_reg;
	logic nrfd_oe_n_reg;
	logic ndac_oe_n_reg;
	logic drive_lvl_reg;
	logic take_byte;
	logic participate;
	gdc_state_s st_reg;

	// Take part under ATN or when addressed to listen
	assign participate = lines.atn | st_reg.listener;
	assign take_byte = (hs_reg == GDC_HS_WAIT) && lines.dav && participate;

	// Wait: NDAC held while taking part, NRFD free. Hold: NRFD held, NDAC free
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			hs_reg <= GDC_HS_WAIT;
			nrfd_oe_n_reg <= 1'b1;
			ndac_oe_n_reg <= 1'b1;
		end
		else
		begin
			case (hs_reg)
				GDC_HS_WAIT:
				begin
					nrfd_oe_n_reg <= 1'b1;
					ndac_oe_n_reg <= ~participate;
					if (take_byte)
					begin
						hs_reg <= GDC_HS_HOLD;
						nrfd_oe_n_reg <= 1'b0;
						ndac_oe_n_reg <= 1'b1;
					end
				end
				GDC_HS_HOLD:
				begin
					if (!lines.dav)
					begin
						hs_reg <= GDC_HS_WAIT;
						nrfd_oe_n_reg <= 1'b1;
						ndac_oe_n_reg <= ~participate;
					end
				end
				default:
				begin
					hs_reg <= GDC_HS_WAIT;
				end
			endcase
		end
	end

	// Driven level of every open drain output is low
	always_ff @(posedge mclk_i)
	begin
		drive_lvl_reg <= 1'b0;
	end

	// ----------------------------------------
	// Command classification
	// ----------------------------------------
	logic [6:0] cmd;
	logic [1:0] grp;
	logic addr_ok;
	logic cmd_stb;
	logic own_lag;
	logic own_tag;
	logic other_tag;
	logic addressed_cmd;

	// Commands only while ATN is true; DIO8 ignored
	assign cmd = lines.dio[6:0];
	assign grp = cmd[GDC_GRP_HI:GDC_GRP_LO];
	assign cmd_stb = take_byte && lines.atn;
	assign addr_ok = (primary_addr_i <= GDC_ADDR_MAX);
	assign own_lag = addr_ok && (cmd == (GDC_LAG_BASE | {2'h0, primary_addr_i}));
	assign own_tag = addr_ok && (cmd == (GDC_TAG_BASE | {2'h0, primary_addr_i}));
	assign other_tag = (grp == GDC_GRP_TAG) && !own_tag && (cmd != GDC_CMD_UNT);
	assign addressed_cmd = cmd_stb && st_reg.listener;

	// ----------------------------------------
	// Addressing state
	// ----------------------------------------
	// IFC wins over any byte; secondary group bytes fall through untouched
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			st_reg.listener <= 1'b0;
			st_reg.talker <= 1'b0;
		end
		else if (lines.ifc)
		begin
			st_reg.listener <= 1'b0;
			st_reg.talker <= 1'b0;
		end
		else if (cmd_stb && (grp != GDC_GRP_SCG))
		begin
			if (cmd == GDC_CMD_UNL)
				st_reg.listener <= 1'b0;
			else if (own_lag)
				st_reg.listener <= 1'b1;
			if (cmd == GDC_CMD_UNT)
				st_reg.talker <= 1'b0;
			else if (own_tag)
				st_reg.talker <= 1'b1;
			else if (other_tag)
				st_reg.talker <= 1'b0;
		end
	end

	// ----------------------------------------
	// Remote, lockout and serial poll
	// ----------------------------------------
	logic ren_prev_reg;

	// Previous filtered REN, to find its rising edge
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			ren_prev_reg <= 1'b0;
		else
			ren_prev_reg <= lines.ren;
	end

	// Remote on REN rise or own listen address; go to local holds local
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			st_reg.remote <= 1'b0;
		else if (!lines.ren)
			st_reg.remote <= 1'b0;
		else if (addressed_cmd && (cmd == GDC_CMD_GTL))
			st_reg.remote <= 1'b0;
		else if (!ren_prev_reg || (cmd_stb && own_lag))
			st_reg.remote <= 1'b1;
	end

	// Lockout from LLO or from REN when so configured
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			st_reg.lockout <= 1'b0;
		else if (!lines.ren)
			st_reg.lockout <= 1'b0;
		else if (addressed_cmd && (cmd == GDC_CMD_GTL))
			st_reg.lockout <= 1'b0;
		else if (cmd_stb && (cmd == GDC_CMD_LLO))
			st_reg.lockout <= 1'b1;
		else if (ren_lockout_cfg_i && !ren_prev_reg)
			st_reg.lockout <= 1'b1;
	end

	// Serial poll mode, universal so no address check
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			st_reg.serial_poll <= 1'b0;
		else if (cmd_stb && (cmd == GDC_CMD_SPE))
			st_reg.serial_poll <= 1'b1;
		else if (cmd_stb && (cmd == GDC_CMD_SPD))
			st_reg.serial_poll <= 1'b0;
	end

	// ----------------------------------------
	// Clear and trigger pulses
	// ----------------------------------------
	logic dev_clear_reg;
	logic trigger_reg;

	// One cycle pulses to the instrument
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			dev_clear_reg <= 1'b0;
			trigger_reg <= 1'b0;
		end
		else
		begin
			dev_clear_reg <= (cmd_stb && (cmd == GDC_CMD_DCL))
				|| (addressed_cmd && (cmd == GDC_CMD_SDC));
			trigger_reg <= addressed_cmd && (cmd == GDC_CMD_GET);
		end
	end

	// ----------------------------------------
	// Device-dependent data path
	// ----------------------------------------
	logic [7:0] data_reg;
	logic data_valid_reg;
	logic data_last_reg;

	// Bytes with ATN false go to the parser, EOI marks the last
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			data_reg <= GDC_BYTE_RST;
			data_valid_reg <= 1'b0;
			data_last_reg <= 1'b0;
		end
		else
		begin
			data_valid_reg <= take_byte && !lines.atn;
			if (take_byte && !lines.atn)
			begin
				data_reg <= lines.dio;
				data_last_reg <= lines.eoi;
			end
		end
	end

	// ----------------------------------------
	// Service request
	// ----------------------------------------
	logic srq_oe_n_reg;

	// Pull SRQ low while the instrument asks for service
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			srq_oe_n_reg <= 1'b1;
		else
			srq_oe_n_reg <= ~srq_request_i;
	end

	// ----------------------------------------
	// Output assignments
	// ----------------------------------------
	assign nrfd_n_o = drive_lvl_reg;
	assign nrfd_oe_n_o = nrfd_oe_n_reg;
	assign ndac_n_o = drive_lvl_reg;
	assign ndac_oe_n_o = ndac_oe_n_reg;
	assign srq_n_o = drive_lvl_reg;
	assign srq_oe_n_o = srq_oe_n_reg;
	assign remote_o = st_reg.remote;
	assign lockout_o = st_reg.lockout;
	assign listener_o = st_reg.listener;
	assign talker_o = st_reg.talker;
	assign serial_poll_o = st_reg.serial_poll;
	assign dev_clear_o = dev_clear_reg;
	assign trigger_o = trigger_reg;
	assign data_o = data_reg;
	assign data_valid_o = data_valid_reg;
	assign data_last_o = data_last_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_ifc_idles_roles: assert property (@(posedge mclk_i) disable iff (reset_i)
		lines.ifc |=> !listener_o && !talker_o)
		else $error("IFC did not idle talker and listener");

	chk_listen_addr_set: assert property (@(posedge mclk_i) disable iff (reset_i)
		cmd_stb && !lines.ifc && own_lag |=> listener_o)
		else $error("Own listen address not taken");

	chk_talk_addr_set: assert property (@(posedge mclk_i) disable iff (reset_i)
		cmd_stb && !lines.ifc && own_tag |=> talker_o)
		else $error("Own talk address not taken");

	chk_data_no_atn: assert property (@(posedge mclk_i) disable iff (reset_i)
		data_valid_o |-> $past(take_byte) && !$past(lines.atn) && data_o == $past(lines.dio))
		else $error("Data byte passed without matching ATN false byte");

	chk_cmd_not_data: assert property (@(posedge mclk_i) disable iff (reset_i)
		cmd_stb |=> !data_valid_o)
		else $error("Command byte leaked to data stream");

	chk_clear_cause: assert property (@(posedge mclk_i) disable iff (reset_i)
		dev_clear_o |-> $past(cmd_stb) && ($past(cmd) == GDC_CMD_DCL
			|| ($past(cmd) == GDC_CMD_SDC && $past(st_reg.listener))))
		else $error("Device clear without DCL or addressed SDC");

	chk_ren_local: assert property (@(posedge mclk_i) disable iff (reset_i)
		!lines.ren |=> !remote_o && !lockout_o)
		else $error("Remote held without REN");

	chk_srq_drive: assert property (@(posedge mclk_i) disable iff (reset_i)
		srq_request_i |=> !srq_oe_n_o)
		else $error("SRQ not driven on request");

	chk_srq_release: assert property (@(posedge mclk_i) disable iff (reset_i)
		!srq_request_i |=> srq_oe_n_o)
		else $error("SRQ held without request");

	chk_gtl_local: assert property (@(posedge mclk_i) disable iff (reset_i)
		addressed_cmd && cmd == GDC_CMD_GTL |=> !remote_o && !lockout_o)
		else $error("Go to local did not return to local");

	chk_local_holds: assert property (@(posedge mclk_i) disable iff (reset_i)
		!remote_o && lines.ren && ren_prev_reg && !(cmd_stb && own_lag) |=> !remote_o)
		else $error("Remote entered without REN rise or listen address");

	chk_secondary_still: assert property (@(posedge mclk_i) disable iff (reset_i)
		cmd_stb && !lines.ifc && grp == GDC_GRP_SCG |=> $stable(listener_o) && $stable(talker_o))
		else $error("Secondary byte changed addressing");

	chk_trigger_addr: assert property (@(posedge mclk_i) disable iff (reset_i)
		trigger_o |-> $past(st_reg.listener) && $past(cmd) == GDC_CMD_GET && $past(cmd_stb))
		else $error("Trigger without addressed GET");

	chk_other_talker: assert property (@(posedge mclk_i) disable iff (reset_i)
		cmd_stb && other_tag && grp != GDC_GRP_SCG |=> !talker_o)
		else $error("Talker kept after other talk address");

	chk_hs_accept: assert property (@(posedge mclk_i) disable iff (reset_i)
		take_byte |=> !nrfd_oe_n_o && ndac_oe_n_o && hs_reg == GDC_HS_HOLD)
		else $error("Handshake did not hold NRFD after taking byte");

endmodule

// ===== inc/gdc_pkg.sv
package gdc_pkg;

	// ----------------------------------------
	// Bus line bundle, true levels after inversion
	// ----------------------------------------
	typedef struct packed {
		logic atn;
		logic ifc;
		logic ren;
		logic eoi;
		logic dav;
		logic [7:0] dio;
	} gdc_lines_s;

	localparam int GDC_LINE_W = 13;

	// ----------------------------------------
	// Acceptor handshake states
	// ----------------------------------------
	typedef enum logic [0:0] {
		GDC_HS_WAIT = 1'b0,
		GDC_HS_HOLD = 1'b1
	} gdc_hs_e;

	// ----------------------------------------
	// Decoded interface state bundle
	// ----------------------------------------
	typedef struct packed {
		logic remote;
		logic lockout;
		logic listener;
		logic talker;
		logic serial_poll;
	} gdc_state_s;

	localparam gdc_state_s GDC_STATE_RST = '{default: 1'b0};
	localparam gdc_lines_s GDC_LINES_RST = '{default: 1'b0};
	localparam logic [7:0] GDC_BYTE_RST = 8'h00;

	// ----------------------------------------
	// Command byte layout: group in bits 6:5
	// ----------------------------------------
	localparam int GDC_GRP_HI = 6;
	localparam int GDC_GRP_LO = 5;
	localparam logic [1:0] GDC_GRP_CMD = 2'h0;
	localparam logic [1:0] GDC_GRP_LAG = 2'h1;
	localparam logic [1:0] GDC_GRP_TAG = 2'h2;
	localparam logic [1:0] GDC_GRP_SCG = 2'h3;
	localparam logic [6:0] GDC_LAG_BASE = 7'h20;
	localparam logic [6:0] GDC_TAG_BASE = 7'h40;
	localparam logic [4:0] GDC_ADDR_MAX = 5'h1e;

	// ----------------------------------------
	// Multiline command codes
	// ----------------------------------------
	localparam logic [6:0] GDC_CMD_GTL = 7'h01;
	localparam logic [6:0] GDC_CMD_SDC = 7'h04;
	localparam logic [6:0] GDC_CMD_GET = 7'h08;
	localparam logic [6:0] GDC_CMD_LLO = 7'h11;
	localparam logic [6:0] GDC_CMD_DCL = 7'h14;
	localparam logic [6:0] GDC_CMD_SPE = 7'h18;
	localparam logic [6:0] GDC_CMD_SPD = 7'h19;
	localparam logic [6:0] GDC_CMD_UNL = 7'h3f;
	localparam logic [6:0] GDC_CMD_UNT = 7'h5f;

endpackage

// ===== test/gdc_ctl_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Bus controller model
// ----------------------------------------
module gdc_ctl_model
(
	// Clock
	input wire logic mclk_i,
	// Acceptor lines as seen on the wire
	input wire logic nrfd_n_i,
	input wire logic ndac_n_i,
	// Controller lines, active low
	output logic atn_n_o,
	output logic ifc_n_o,
	output logic ren_n_o,
	output logic eoi_n_o,
	output logic dav_n_o,
	output logic [7:0] dio_n_o
);
	int gap = 6;
	logic accepted = 1'b0;
	// All lines released at start
	initial
	begin
		atn_n_o = 1'b1;
		ifc_n_o = 1'b1;
		ren_n_o = 1'b1;
		eoi_n_o = 1'b1;
		dav_n_o = 1'b1;
		dio_n_o = 8'hff;
	end
	// One byte with source handshake, ATN kept until next byte
	task automatic send(input logic atn, input logic [7:0] b, input logic eoi);
		@(posedge mclk_i);
		#1;
		atn_n_o = ~atn;
		dio_n_o = ~b;
		eoi_n_o = ~eoi;
		repeat (gap) @(posedge mclk_i);
		#1;
		dav_n_o = 1'b0;
		// Wait for data accepted, bounded
		repeat (20)
		begin
			@(posedge mclk_i);
			#1;
			if (ndac_n_i === 1'b1)
				break;
		end
		accepted = (nrfd_n_i === 1'b0);
		// Let NDAC be sampled high at an edge before releasing DAV
		@(posedge mclk_i);
		#1;
		dav_n_o = 1'b1;
		repeat (gap) @(posedge mclk_i);
		#1;
		eoi_n_o = 1'b1;
		dio_n_o = 8'hff; // Released lines float to the pull-up level
	endtask
endmodule

// ===== test/tb.sv
`timescale 1ns/100ps
module tb
	import gdc_pkg::*;
;
	localparam logic [4:0] PA = 5'h1c;
	localparam logic [7:0] LAG_B = 8'h20 | {3'h0, PA};
	localparam logic [7:0] TAG_B = 8'h40 | {3'h0, PA};
	logic mclk_i;
	logic reset_i = 1'b1;
	logic [4:0] primary_addr_i = PA;
	logic ren_lockout_cfg_i = 1'b0;
	logic srq_request_i = 1'b0;
	wire logic atn_n, ifc_n, ren_n, eoi_n, dav_n;
	wire logic [7:0] dio_n;
	logic nrfd_n_o, nrfd_oe_n_o, ndac_n_o, ndac_oe_n_o, srq_n_o, srq_oe_n_o;
	logic remote_o, lockout_o, listener_o, talker_o, serial_poll_o;
	logic dev_clear_o, trigger_o, data_valid_o, data_last_o;
	logic [7:0] data_o;
	int fails = 0;
	int n_compared = 0;
	int n_data = 0;
	int n_clr = 0;
	int n_trig = 0;
	int n_rfall = 0;
	logic remote_q = 1'b0;
	// ----------------------------------------
	// Wire levels of open-drain lines
	// ----------------------------------------
	wire logic nrfd_w = nrfd_oe_n_o ? 1'b1 : nrfd_n_o;
	wire logic ndac_w = ndac_oe_n_o ? 1'b1 : ndac_n_o;
	wire logic srq_w = srq_oe_n_o ? 1'b1 : srq_n_o;
	gdc_ctl_model ctl (.mclk_i(mclk_i), .nrfd_n_i(nrfd_w), .ndac_n_i(ndac_w), .atn_n_o(atn_n), .ifc_n_o(ifc_n),
		.ren_n_o(ren_n), .eoi_n_o(eoi_n), .dav_n_o(dav_n), .dio_n_o(dio_n));
	gdc_decoder dut (.mclk_i(mclk_i), .reset_i(reset_i), .atn_n_i(atn_n), .ifc_n_i(ifc_n), .ren_n_i(ren_n),
		.eoi_n_i(eoi_n), .dav_n_i(dav_n), .dio_n_i(dio_n), .nrfd_n_i(nrfd_w), .nrfd_n_o(nrfd_n_o),
		.nrfd_oe_n_o(nrfd_oe_n_o), .ndac_n_i(ndac_w), .ndac_n_o(ndac_n_o), .ndac_oe_n_o(ndac_oe_n_o),
		.srq_n_i(srq_w), .srq_n_o(srq_n_o), .srq_oe_n_o(srq_oe_n_o), .primary_addr_i(primary_addr_i),
		.ren_lockout_cfg_i(ren_lockout_cfg_i), .srq_request_i(srq_request_i), .remote_o(remote_o),
		.lockout_o(lockout_o), .listener_o(listener_o), .talker_o(talker_o), .serial_poll_o(serial_poll_o),
		.dev_clear_o(dev_clear_o), .trigger_o(trigger_o), .data_o(data_o), .data_valid_o(data_valid_o),
		.data_last_o(data_last_o));
	// Clock
	initial
	begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	// Pulse and edge counters, sampled mid-cycle
	always @(negedge mclk_i)
	begin
		if (data_valid_o === 1'b1) n_data++;
		if (dev_clear_o === 1'b1) n_clr++;
		if (trigger_o === 1'b1) n_trig++;
		if (remote_q === 1'b1 && remote_o === 1'b0) n_rfall++;
		remote_q = remote_o;
	end
	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (fails == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	function automatic logic [7:0] cmd(input logic [6:0] c);
		return {1'b0, c};
	endfunction
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_listen_data();
		int d0 = n_data;
		ctl.send(1'b1, LAG_B, 1'b0);
		chk(8'(listener_o), 8'h01, "listen");
		ctl.send(1'b0, 8'h52, 1'b0);
		chk(8'(ctl.accepted), 8'h01, "accept");
		chk(data_o, 8'h52, "data");
		chk(8'(data_last_o), 8'h00, "last");
		ctl.gap = 12;
		ctl.send(1'b0, 8'h31, 1'b1);
		ctl.gap = 6;
		chk(data_o, 8'h31, "data2");
		chk(8'(data_last_o), 8'h01, "last2");
		ctl.send(1'b1, cmd(GDC_CMD_UNL), 1'b0);
		chk(8'(n_data - d0), 8'h02, "data count");
		chk(8'(listener_o), 8'h00, "unlisten");
	endtask
	task automatic t_talk();
		ctl.send(1'b1, TAG_B, 1'b0);
		chk(8'(talker_o), 8'h01, "talk");
		ctl.send(1'b1, 8'h45, 1'b0);
		chk(8'(talker_o), 8'h00, "other talk");
		ctl.send(1'b1, TAG_B, 1'b0);
		ctl.send(1'b1, cmd(GDC_CMD_UNT), 1'b0);
		chk(8'(talker_o), 8'h00, "untalk");
	endtask
	task automatic t_second_ifc();
		ctl.send(1'b1, LAG_B, 1'b0);
		ctl.send(1'b1, TAG_B, 1'b0);
		ctl.send(1'b1, 8'h60 | {3'h0, PA}, 1'b0);
		chk({6'h0, listener_o, talker_o}, 8'h03, "secondary");
		ctl.ifc_n_o = 1'b0;
		cyc(6);
		ctl.ifc_n_o = 1'b1;
		cyc(6);
		chk({6'h0, listener_o, talker_o}, 8'h00, "ifc");
	endtask
	task automatic t_addressed();
		int c0 = n_clr;
		int g0 = n_trig;
		int d0 = n_data;
		ctl.send(1'b1, cmd(GDC_CMD_SDC), 1'b0);
		ctl.send(1'b1, cmd(GDC_CMD_GET), 1'b0);
		chk(8'(n_clr - c0), 8'h00, "sdc unaddr");
		chk(8'(n_trig - g0), 8'h00, "get unaddr");
		ctl.send(1'b0, 8'h41, 1'b0);
		chk(8'(ctl.accepted), 8'h00, "refuse");
		chk(8'(n_data - d0), 8'h00, "no data");
		ctl.send(1'b1, LAG_B, 1'b0);
		ctl.send(1'b1, cmd(GDC_CMD_SDC), 1'b0);
		chk(8'(n_clr - c0), 8'h01, "sdc");
		ctl.send(1'b1, cmd(GDC_CMD_GET), 1'b0);
		chk(8'(n_trig - g0), 8'h01, "get");
	endtask
	task automatic t_universal();
		int c0;
		ctl.send(1'b1, cmd(GDC_CMD_UNL), 1'b0);
		c0 = n_clr;
		ctl.send(1'b1, cmd(GDC_CMD_DCL), 1'b0);
		chk(8'(n_clr - c0), 8'h01, "dcl");
		ctl.send(1'b1, cmd(GDC_CMD_SPE), 1'b0);
		chk(8'(serial_poll_o), 8'h01, "spe");
		ctl.send(1'b1, cmd(GDC_CMD_SPD), 1'b0);
		chk(8'(serial_poll_o), 8'h00, "spd");
	endtask
	task automatic t_remote();
		int r0;
		ren_lockout_cfg_i = 1'b1;
		ctl.ren_n_o = 1'b0;
		cyc(8);
		chk({6'h0, remote_o, lockout_o}, 8'h03, "ren lock");
		ctl.ren_n_o = 1'b1;
		ren_lockout_cfg_i = 1'b0;
		cyc(8);
		chk({6'h0, remote_o, lockout_o}, 8'h00, "ren off");
		ctl.ren_n_o = 1'b0;
		cyc(8);
		chk({6'h0, remote_o, lockout_o}, 8'h02, "ren");
		ctl.send(1'b1, cmd(GDC_CMD_LLO), 1'b0);
		chk(8'(lockout_o), 8'h01, "llo");
		r0 = n_rfall;
		ctl.send(1'b1, LAG_B, 1'b0);
		ctl.send(1'b1, cmd(GDC_CMD_GTL), 1'b0);
		chk(8'(n_rfall - r0), 8'h01, "gtl");
		chk(8'(remote_o), 8'h00, "gtl local");
		chk(8'(lockout_o), 8'h00, "gtl unlock");
		ctl.ren_n_o = 1'b1;
		cyc(8);
	endtask
	task automatic t_srq();
		srq_request_i = 1'b1;
		cyc(2);
		chk(8'(srq_w), 8'h00, "srq on");
		srq_request_i = 1'b0;
		cyc(2);
		chk(8'(srq_w), 8'h01, "srq off");
	endtask
	task automatic t_reset();
		ctl.send(1'b1, LAG_B, 1'b0);
		reset_i = 1'b1;
		cyc(4);
		chk({3'h0, remote_o, lockout_o, listener_o, talker_o, serial_poll_o}, 8'h00, "reset state");
		chk({6'h0, nrfd_w, ndac_w}, 8'h03, "reset lines");
		reset_i = 1'b0;
		cyc(4);
		ctl.send(1'b1, LAG_B, 1'b0);
		chk(8'(listener_o), 8'h01, "listen again");
	endtask
	// Main sequence
	initial
	begin
		repeat (20) @(posedge mclk_i);
		#1;
		reset_i = 1'b0;
		cyc(4);
		t_listen_data();
		t_talk();
		t_second_ifc();
		t_addressed();
		t_universal();
		t_remote();
		t_srq();
		t_reset();
		give_verdict();
	end
	// Watchdog, far beyond the expected few hundred cycles
	initial
	begin
		#300000;
		fails++;
		give_verdict();
	end
endmodule
